// >>> bst_ctl_model.sv
// test controller model: drives tck, tms, tdi and samples tdo
`timescale 1ns/1ps
module bst_ctl_model import bst_pkg::*; (
    input wire logic mclk, // system clock, pins timed from it
    output bst_pins_t jtag, // tck, tms, tdi to the port
    input wire logic tdo // serial data back
);
    initial jtag = BST_PINS_IDLE;
    // 160 ns tck: low half then high half; tdo read just before the rise
    task automatic tck_bit(input logic m, input logic d, output logic o);
        @(posedge mclk);
        jtag <= '{tck: 1'b0, tms: m, tdi: d};
        repeat (10) @(posedge mclk);
        o = tdo;
        jtag.tck <= 1'b1;
        repeat (9) @(posedge mclk);
    endtask
    // rti to rti; tdi released high outside shifting, as the pull-up would
    task automatic scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
        logic o;
        dout = '0;
        tck_bit(1'b1, 1'b1, o);
        if (ir) tck_bit(1'b1, 1'b1, o);
        tck_bit(1'b0, 1'b1, o);
        tck_bit(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            tck_bit(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tck_bit(1'b1, 1'b1, o);
        tck_bit(1'b0, 1'b1, o);
    endtask
    task automatic tap_reset();
        logic o;
        repeat (5) tck_bit(1'b1, 1'b1, o);
        tck_bit(1'b0, 1'b1, o);
    endtask
endmodule

// >>> bst_pkg.sv
// constants and types for the boundary-scan test port
package bst_pkg;
    localparam int BST_IR_W = 10;
    localparam int BST_WORD_W = 32;
    localparam int BST_USER_W = 7;
    localparam int BST_FIXED_W = 25;
    localparam int BST_BSR_LEN_DEF = 438;
    // ir capture pattern: low two bits 01
    localparam logic [9:0] BST_IR_CAPT = 10'h001;
    localparam logic [9:0] BST_OP_BYPASS = 10'h3ff;
    localparam logic [9:0] BST_OP_EXTEST = 10'h000;
    localparam logic [9:0] BST_OP_SAMPLE = 10'h005;
    localparam logic [9:0] BST_OP_IDCODE = 10'h006;
    localparam logic [9:0] BST_OP_USERCODE = 10'h007;
    localparam logic [9:0] BST_OP_CFGLOAD = 10'h002;
    // identity and fixed signature fields: arbitrary values
    localparam logic [3:0] BST_ID_VER = 4'h3;
    localparam logic [15:0] BST_ID_PART = 16'h5a5a;
    localparam logic [10:0] BST_ID_MFR = 11'h2a5;
    localparam logic [24:0] BST_UC_FIXED = 25'h0c0ffee;
    localparam logic [31:0] BST_IDCODE = {BST_ID_VER, BST_ID_PART, BST_ID_MFR, 1'b1};

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } bst_tap_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bst_pins_t;

    // pulled-up idle level of the test inputs
    localparam bst_pins_t BST_PINS_IDLE = 3'h7;
endpackage

// >>> bst_tap.sv
// boundary-scan test access port with id, signature, bypass, boundary and config-load paths
`timescale 1ns/1ps
// Behaviour
// RULE1: instruction register is ten bits between test input and test output
// RULE2: signature register is 32 bits, seven from user, twenty-five fixed
// RULE3: bypass places one flop between test input and output
// RULE4: signature instruction shifts the signature register out
// RULE5: identification instruction shifts the 32-bit identification code out
// RULE6: code is version 4, part 16, maker 11, then one bit
// RULE7: lowest identification bit always reads one
// RULE8: boundary chain length set per part variant
// RULE9: sample/preload snapshots pins and preloads, pins keep normal operation
// RULE10: external test drives preloaded pattern on pins, captures input pins
// RULE11: boundary testing not supported while configuration is in progress
// RULE12: configuration-load instructions feed fabric configuration through the port
// RULE13: undriven test inputs are seen as logic one
// RULE14: outputs undriven during power-up until operation begins
// RULE15: standard sixteen-state tap, tms on rising tck, tdo on falling
// RULE16: opcodes are parameters, bypass opcode all ones
module bst_tap import bst_pkg::*; #(
    parameter int BSR_LEN = BST_BSR_LEN_DEF,
    parameter logic [9:0] OP_BYPASS = BST_OP_BYPASS,
    parameter logic [9:0] OP_EXTEST = BST_OP_EXTEST,
    parameter logic [9:0] OP_SAMPLE = BST_OP_SAMPLE,
    parameter logic [9:0] OP_IDCODE = BST_OP_IDCODE,
    parameter logic [9:0] OP_USERCODE = BST_OP_USERCODE,
    parameter logic [9:0] OP_CFGLOAD = BST_OP_CFGLOAD
) (
    input wire logic mclk, // system clock
    input wire logic nrst, // sync reset, low active
    input wire bst_pins_t jtag, // tck, tms, tdi pins
    output logic tdo, // serial test output
    output logic tdo_oe_n, // low while tdo driven
    input wire logic [BSR_LEN-1:0] pin_in, // device pin levels
    input wire logic [BSR_LEN-1:0] core_out, // fabric output values
    input wire logic [BSR_LEN-1:0] core_oe_n, // fabric output enables
    output logic [BSR_LEN-1:0] pin_out, // pin output values
    output logic [BSR_LEN-1:0] pin_oe_n, // pin enables, low drives
    input wire logic [BST_USER_W-1:0] user_bits, // user signature bits
    input wire logic cfg_busy, // configuration in progress
    output logic cfg_valid, // config bit strobe
    output logic cfg_data // config bit
);
    bst_pins_t s1_q, s2_q;
    logic tck3_q;
    logic [BSR_LEN-1:0] pin_s1_q, pin_s2_q;
    logic rise, fall;

    bst_tap_t st_q, st_d;
    logic [9:0] ir_sr_q, ir_sr_d, ir_q, ir_d;
    logic byp_q, byp_d;
    logic [31:0] word_q, word_d;
    logic [BSR_LEN-1:0] bsr_q, bsr_d, upd_q, upd_d;
    logic tdo_q, tdo_d, tdo_oe_n_q, tdo_oe_n_d;
    logic cfg_valid_q, cfg_valid_d, cfg_data_q, cfg_data_d;
    logic [BSR_LEN-1:0] pin_out_q, pin_out_d, pin_oe_n_q, pin_oe_n_d;
    logic tdo_src;
    logic drive_test;

    function automatic logic bsr_sel(logic [9:0] op);
        return (op == OP_EXTEST) || (op == OP_SAMPLE);
    endfunction

    function automatic bst_tap_t bst_tap_next(bst_tap_t s, logic m);
        bst_tap_t n;
        n = s;
        case (s)
            TLR: n = m ? TLR : RTI;
            RTI: n = m ? SEL_DR : RTI;
            SEL_DR: n = m ? SEL_IR : CAP_DR;
            CAP_DR: n = m ? EX1_DR : SH_DR;
            SH_DR: n = m ? EX1_DR : SH_DR;
            EX1_DR: n = m ? UPD_DR : PAU_DR;
            PAU_DR: n = m ? EX2_DR : PAU_DR;
            EX2_DR: n = m ? UPD_DR : SH_DR;
            UPD_DR: n = m ? SEL_DR : RTI;
            SEL_IR: n = m ? TLR : CAP_IR;
            CAP_IR: n = m ? EX1_IR : SH_IR;
            SH_IR: n = m ? EX1_IR : SH_IR;
            EX1_IR: n = m ? UPD_IR : PAU_IR;
            PAU_IR: n = m ? EX2_IR : PAU_IR;
            EX2_IR: n = m ? UPD_IR : SH_IR;
            UPD_IR: n = m ? SEL_DR : RTI;
            default: n = TLR;
        endcase
        return n;
    endfunction

    // synchronisers; test-input stages reset to the pulled-up level, device-pin stages to zero
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s1_q <= BST_PINS_IDLE; // RULE13
            s2_q <= BST_PINS_IDLE; // RULE13
            tck3_q <= 1'b1;
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            s1_q <= jtag;
            s2_q <= s1_q;
            tck3_q <= s2_q.tck;
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    assign rise = s2_q.tck & ~tck3_q;
    assign fall = ~s2_q.tck & tck3_q;

    always_comb begin
        if (st_q == SH_IR) begin
            tdo_src = ir_sr_q[0]; // RULE1
        end else if (ir_q == OP_IDCODE || ir_q == OP_USERCODE) begin
            tdo_src = word_q[0]; // RULE4 RULE5
        end else if (bsr_sel(ir_q)) begin
            tdo_src = bsr_q[0]; // RULE8
        end else begin
            tdo_src = byp_q; // RULE3
        end
    end

    always_comb begin
        st_d = st_q;
        ir_sr_d = ir_sr_q;
        ir_d = ir_q;
        byp_d = byp_q;
        word_d = word_q;
        bsr_d = bsr_q;
        upd_d = upd_q;
        tdo_d = tdo_q;
        tdo_oe_n_d = tdo_oe_n_q;
        cfg_valid_d = 1'b0;
        cfg_data_d = cfg_data_q;
        if (rise) begin
            st_d = bst_tap_next(st_q, s2_q.tms); // RULE15
            case (st_q)
                TLR: ir_d = OP_IDCODE; // RULE16
                CAP_IR: ir_sr_d = BST_IR_CAPT;
                SH_IR: ir_sr_d = {s2_q.tdi, ir_sr_q[9:1]}; // RULE1
                UPD_IR: ir_d = ir_sr_q;
                CAP_DR: begin
                    byp_d = 1'b0;
                    if (ir_q == OP_IDCODE) begin
                        word_d = BST_IDCODE; // RULE5 RULE6 RULE7
                    end else if (ir_q == OP_USERCODE) begin
                        word_d = {BST_UC_FIXED, user_bits}; // RULE2 RULE4
                    end
                    // capture refused while configuring
                    if (bsr_sel(ir_q) && !cfg_busy) begin
                        bsr_d = pin_s2_q; // RULE9 RULE10 RULE11
                    end
                end
                SH_DR: begin
                    byp_d = s2_q.tdi; // RULE3
                    word_d = {s2_q.tdi, word_q[31:1]};
                    bsr_d = {s2_q.tdi, bsr_q[BSR_LEN-1:1]}; // RULE8
                    if (ir_q == OP_CFGLOAD) begin
                        cfg_valid_d = 1'b1; // RULE12
                        cfg_data_d = s2_q.tdi;
                    end
                end
                UPD_DR: begin
                    if (bsr_sel(ir_q) && !cfg_busy) begin
                        upd_d = bsr_q; // RULE9 RULE11
                    end
                end
                default: ;
            endcase
        end
        if (fall) begin
            tdo_d = tdo_src; // RULE15
            tdo_oe_n_d = !(st_q == SH_IR || st_q == SH_DR);
        end
    end

    // sample leaves the fabric in charge of the pins
    assign drive_test = (ir_q == OP_EXTEST) && !cfg_busy;

    always_comb begin
        if (drive_test) begin
            pin_out_d = upd_q; // RULE10
            pin_oe_n_d = '0;
        end else begin
            pin_out_d = core_out; // RULE9
            pin_oe_n_d = core_oe_n;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st_q <= TLR;
            ir_sr_q <= BST_IR_CAPT;
            ir_q <= OP_IDCODE;
            byp_q <= 1'b0;
            word_q <= '0;
            bsr_q <= '0;
            upd_q <= '0;
            tdo_q <= 1'b1;
            tdo_oe_n_q <= 1'b1; // RULE14
            cfg_valid_q <= 1'b0;
            cfg_data_q <= 1'b0;
            pin_out_q <= '0;
            pin_oe_n_q <= '1; // RULE14
        end else begin
            st_q <= st_d;
            ir_sr_q <= ir_sr_d;
            ir_q <= ir_d;
            byp_q <= byp_d;
            word_q <= word_d;
            bsr_q <= bsr_d;
            upd_q <= upd_d;
            tdo_q <= tdo_d;
            tdo_oe_n_q <= tdo_oe_n_d;
            cfg_valid_q <= cfg_valid_d;
            cfg_data_q <= cfg_data_d;
            pin_out_q <= pin_out_d;
            pin_oe_n_q <= pin_oe_n_d;
        end
    end

    assign tdo = tdo_q;
    assign tdo_oe_n = tdo_oe_n_q;
    assign pin_out = pin_out_q;
    assign pin_oe_n = pin_oe_n_q;
    assign cfg_valid = cfg_valid_q;
    assign cfg_data = cfg_data_q;

    chk_ir_capture: assert property ( // RULE1
        @(posedge mclk) disable iff (!nrst)
        (rise && st_q == CAP_IR) |=> (ir_sr_q == BST_IR_CAPT) && (st_q != CAP_IR || !rise))
        else $error("ir capture pattern wrong");

    chk_ir_shift: assert property ( // RULE1
        @(posedge mclk) disable iff (!nrst)
        (rise && st_q == SH_IR) |=> ir_sr_q == {$past(s2_q.tdi), $past(ir_sr_q[9:1])})
        else $error("ir shift wrong");

    chk_bypass_delay: assert property ( // RULE3
        @(posedge mclk) disable iff (!nrst)
        (rise && st_q == SH_DR && ir_q == OP_BYPASS) |=> byp_q == $past(s2_q.tdi))
        else $error("bypass stage wrong");

    chk_id_capture: assert property ( // RULE5
        @(posedge mclk) disable iff (!nrst)
        (rise && st_q == CAP_DR && ir_q == OP_IDCODE) |=> word_q[31:1] == {BST_ID_VER, BST_ID_PART, BST_ID_MFR})
        else $error("idcode capture wrong");

    chk_id_lsb: assert property ( // RULE7
        @(posedge mclk) disable iff (!nrst)
        (rise && st_q == CAP_DR && ir_q == OP_IDCODE) |=> word_q[0])
        else $error("idcode lsb not one");

    chk_uc_capture: assert property ( // RULE2
        @(posedge mclk) disable iff (!nrst)
        (rise && st_q == CAP_DR && ir_q == OP_USERCODE)
        |=> word_q[31:7] == BST_UC_FIXED && word_q[6:0] == $past(user_bits))
        else $error("usercode capture wrong");

    chk_tdo_fall: assert property ( // RULE15
        @(posedge mclk) disable iff (!nrst)
        $changed(tdo_oe_n_q) |-> $past(fall))
        else $error("tdo enable moved off falling tck");

    chk_tlr_instr: assert property ( // RULE16
        @(posedge mclk) disable iff (!nrst)
        (rise && st_q == TLR) |=> ir_q == OP_IDCODE && st_q == ($past(s2_q.tms) ? TLR : RTI))
        else $error("test logic reset wrong");

    chk_extest_drive: assert property ( // RULE10
        @(posedge mclk) disable iff (!nrst)
        drive_test |=> pin_out_q == $past(upd_q) && pin_oe_n_q == '0)
        else $error("extest pattern not driven");

    chk_sample_pass: assert property ( // RULE9
        @(posedge mclk) disable iff (!nrst)
        (ir_q == OP_SAMPLE) |=> pin_out_q == $past(core_out))
        else $error("sample disturbed pins");

    chk_busy_frozen: assert property ( // RULE11
        @(posedge mclk) disable iff (!nrst)
        cfg_busy |=> $stable(upd_q))
        else $error("update during configuration");

    chk_reset_hiz: assert property ( // RULE14
        @(posedge mclk) disable iff (!nrst)
        $rose(nrst) |-> tdo_oe_n_q && pin_oe_n_q == '1)
        else $error("outputs driven at reset");

    chk_cfg_strobe: assert property ( // RULE12
        @(posedge mclk) disable iff (!nrst)
        cfg_valid_q |-> $past(rise) && $past(st_q) == SH_DR && ir_q == OP_CFGLOAD)
        else $error("stray config strobe");

    chk_cfg_data: assert property ( // RULE12
        @(posedge mclk) disable iff (!nrst)
        (rise && st_q == SH_DR && ir_q == OP_CFGLOAD) |=> cfg_valid_q && cfg_data_q == $past(s2_q.tdi))
        else $error("config bit not passed on");

    chk_bsr_capture: assert property ( // RULE9
        @(posedge mclk) disable iff (!nrst)
        (rise && st_q == CAP_DR && bsr_sel(ir_q) && !cfg_busy) |=> bsr_q == $past(pin_s2_q))
        else $error("boundary capture wrong");

    chk_bsr_shift: assert property ( // RULE8
        @(posedge mclk) disable iff (!nrst)
        (rise && st_q == SH_DR) |=> bsr_q == {$past(s2_q.tdi), $past(bsr_q[BSR_LEN-1:1])})
        else $error("boundary shift wrong");

    chk_tdo_word: assert property ( // RULE4 RULE5
        @(posedge mclk) disable iff (!nrst)
        (fall && st_q == SH_DR && (ir_q == OP_IDCODE || ir_q == OP_USERCODE)) |=> tdo_q == $past(word_q[0]) && !tdo_oe_n_q)
        else $error("word bit not on tdo");
endmodule

// >>> tb_top.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module tb_top;
    import bst_pkg::*;
    localparam int BL = 16;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    bst_pins_t jtag;
    logic tdo, tdo_oe_n, cfg_valid, cfg_data;
    logic cfg_busy = 1'b0;
    logic [BL-1:0] pin_in = 16'h0000, core_out = 16'h0000, core_oe_n = 16'hffff, pin_out, pin_oe_n;
    logic [6:0] user_bits = 7'h00;
    logic [31:0] r, cfg_sh = '0;
    int num_errors = 0, n_tests = 0, n_cfg = 0, cyc = 0, n_oe = 0;
    always #4 mclk = ~mclk;
    bst_tap #(.BSR_LEN(BL)) dut_u (.mclk(mclk), .nrst(nrst), .jtag(jtag), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .pin_in(pin_in), .core_out(core_out), .core_oe_n(core_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .user_bits(user_bits), .cfg_busy(cfg_busy), .cfg_valid(cfg_valid), .cfg_data(cfg_data));
    bst_ctl_model ctl_u (.mclk(mclk), .jtag(jtag), .tdo(tdo));
    // config bits arrive lsb first, so shift in from the top
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (tdo_oe_n === 1'b0) begin
            n_oe <= n_oe + 1;
        end
        if (cfg_valid === 1'b1) begin
            cfg_sh <= {cfg_data, cfg_sh[31:1]};
            n_cfg <= n_cfg + 1;
        end
        if (cyc == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic t_idcode();
        int k;
        check({31'h0, tdo_oe_n}, 32'h1, "tdo idle");
        ctl_u.tap_reset();
        k = n_oe;
        ctl_u.scan(1'b0, '1, 32, r);
        check(32'(n_oe - k), 32'h280, "tdo drive cycles");
        check(r, BST_IDCODE, "idcode");
        check({21'h0, r[11:1]}, {21'h0, BST_ID_MFR}, "maker field");
        check({31'h0, r[0]}, 32'h1, "id lsb");
        $display("test idcode done");
    endtask
    task automatic t_user();
        logic [6:0] v [2] = '{7'h5b, 7'h24};
        ctl_u.scan(1'b1, {22'h0, BST_OP_USERCODE}, 10, r);
        check(r, {22'h0, BST_IR_CAPT}, "ir capture");
        for (int i = 0; i < 2; i++) begin
            user_bits <= v[i];
            ctl_u.scan(1'b0, '0, 32, r);
            check(r, {BST_UC_FIXED, v[i]}, "signature");
        end
        $display("test signature done");
    endtask
    task automatic t_bypass();
        logic [9:0] ops [2] = '{BST_OP_BYPASS, 10'h155};
        for (int i = 0; i < 2; i++) begin
            ctl_u.scan(1'b1, {22'h0, ops[i]}, 10, r);
            ctl_u.scan(1'b0, 32'h1b5, 9, r);
            check(r, {23'h0, 8'hb5, 1'b0}, "bypass delay");
        end
        ctl_u.tap_reset();
        ctl_u.scan(1'b0, '0, 32, r);
        check(r, BST_IDCODE, "tms reset");
        $display("test bypass done");
    endtask
    task automatic t_boundary();
        pin_in <= 16'hc3a5;
        core_out <= 16'h1234;
        core_oe_n <= 16'h00ff;
        ctl_u.scan(1'b1, {22'h0, BST_OP_SAMPLE}, 10, r);
        ctl_u.scan(1'b0, 32'h5e71, BL, r);
        check(r, 32'hc3a5, "sample capture");
        check({16'h0, pin_out}, 32'h1234, "pins undisturbed");
        check({16'h0, pin_oe_n}, 32'h00ff, "enables undisturbed");
        ctl_u.scan(1'b1, {22'h0, BST_OP_EXTEST}, 10, r);
        check({16'h0, pin_out}, 32'h5e71, "preload driven");
        check({16'h0, pin_oe_n}, 32'h0, "extest drives");
        pin_in <= 16'h0f0f;
        ctl_u.scan(1'b0, 32'h5e71, BL, r);
        check(r, 32'h0f0f, "extest capture");
        cfg_busy <= 1'b1;
        core_out <= 16'h4321;
        repeat (4) @(posedge mclk);
        check({16'h0, pin_out}, 32'h4321, "no drive while busy");
        check({16'h0, pin_oe_n}, 32'h00ff, "enables while busy");
        cfg_busy <= 1'b0;
        $display("test boundary done");
    endtask
    task automatic t_cfg();
        int k;
        ctl_u.scan(1'b1, {22'h0, BST_OP_CFGLOAD}, 10, r);
        k = n_cfg;
        ctl_u.scan(1'b0, 32'ha7, 8, r);
        repeat (4) @(posedge mclk);
        check(32'(n_cfg - k), 32'h8, "config strobes");
        check({24'h0, cfg_sh[31:24]}, 32'ha7, "config data");
        $display("test config done");
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (9) @(posedge mclk);
        check({16'h0, pin_oe_n}, 32'hffff, "pins off in reset");
        @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        t_idcode();
        t_user();
        t_bypass();
        t_boundary();
        t_cfg();
        stop_test();
    end
endmodule
